//--- core/spi_mem_pkg.sv
package spi_mem_pkg;
  // field and frame sizes
  localparam int BYTE_BITS   = 8;
  localparam int ADDR_BYTES  = 3;
  localparam int ADDR_USED   = 19;
  localparam int ADDR_IGNORE = 5;
  // timing
  localparam int CLK_HZ      = 20_000_000;
  localparam int SCK_MAX_HZ  = 20_000_000;
  // opcode values seen by the front end (names coined, values plain)
  localparam logic [7:0] OP_WRITE  = 8'h02;
  localparam logic [7:0] OP_READ   = 8'h03;
  localparam logic [7:0] OP_RDSTAT = 8'h05;
  localparam logic [7:0] OP_WRSTAT = 8'h01;
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDIS  = 8'h04;
  // status register value after power-up
  localparam logic [7:0] STATUS_RESET = 8'h40;
  localparam logic [7:0] STATUS_WMASK = 8'h8c;
  localparam logic [7:0] STATUS_WEL   = 8'h02;
  // master side divider: half period in clk cycles
  localparam int SCK_HALF_CYCLES = 4;
  // power-up access delay in ns and cycles
  localparam int POWERUP_ACCESS_DELAY_NS = 250_000;
  localparam int POWERUP_CYCLES =
    (POWERUP_ACCESS_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
endpackage

//--- core/spi_mem_if.sv
`timescale 1ns/10ps
`default_nettype none
interface spi_mem_if;
  logic selN;     // chip select, active low
  logic sck;      // serial clock from master
  logic mosi;     // master to device data
  logic misoOut;  // device output value
  logic misoOeN;  // device output enable, low drives
  logic misoLine; // data line as the master sees it
  // released line has no pull, so it shows the inverse of the last bit
  assign misoLine = misoOeN ? ~misoOut : misoOut;
  modport device (input selN, input sck, input mosi, output misoOut, output misoOeN);
  modport master (output selN, output sck, output mosi, input misoLine);
endinterface
`default_nettype wire

//--- core/spi_mem_device.sv
`timescale 1ns/10ps
`default_nettype none
module spi_mem_device
  import spi_mem_pkg::*;
#(
  parameter int MEM_DEPTH = 2 ** ADDR_USED
) (
  // system
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // serial link
  spi_mem_if.device                 link,
  // status
  output logic                      modeThree,
  output logic                      opcodeBad,
  output logic [7:0]                statusReg
);
  initial begin
    if (MEM_DEPTH < 1 || MEM_DEPTH > 2 ** ADDR_USED) $error("bad MEM_DEPTH");
  end

  typedef enum {S_IDLE, S_OPCODE, S_ADDR, S_DATA, S_STAT, S_IGNORE} state_e;

  logic [7:0] mem [MEM_DEPTH];

  // pin synchronisers, first stage read only by the second
  logic [1:0] selSync_q, sckSync_q, mosiSync_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      selSync_q  <= 2'h3;
      sckSync_q  <= 2'h0;
      mosiSync_q <= 2'h0;
    end else begin
      selSync_q  <= {selSync_q[0], link.selN};
      sckSync_q  <= {sckSync_q[0], link.sck};
      mosiSync_q <= {mosiSync_q[0], link.mosi};
    end
  end

  logic                 sel, sckS, mosiS;
  assign sel   = ~selSync_q[1];
  assign sckS  = sckSync_q[1];
  assign mosiS = mosiSync_q[1];

  state_e               state_q, state_d;
  logic                 selPrev_q, sckPrev_q;
  logic                 armed_q, armed_d;    // mode 3 waits for first low
  logic                 mode_q, mode_d;
  logic [2:0]           bitCnt_q, bitCnt_d;
  logic [7:0]           shift_q, shift_d;
  logic [7:0]           op_q, op_d;
  logic [1:0]           addrCnt_q, addrCnt_d;
  logic [23:0]          addr_q, addr_d;
  logic [7:0]           txByte_q, txByte_d;
  logic                 tx_q, tx_d;          // in a read phase
  logic                 misoOut_q, misoOut_d;
  logic                 misoOeN_q, misoOeN_d;
  logic [7:0]           stat_q, stat_d;
  logic                 clrWel_q, clrWel_d;
  logic                 bad_q, bad_d;
  logic                 memWe;
  logic [ADDR_USED-1:0] memAddr;

  logic selFall, selRise, sckRise, sckFall;
  assign selFall = sel & ~selPrev_q;
  assign selRise = ~sel & selPrev_q;
  assign sckRise = sckS & ~sckPrev_q;
  assign sckFall = ~sckS & sckPrev_q;
  assign memAddr = addr_q[ADDR_USED-1:0];  // leading bits dropped

  // next state of the serial engine
  always_comb begin
    logic [7:0] nb;
    nb        = {shift_q[6:0], mosiS};      // msb first
    state_d   = state_q;
    armed_d   = armed_q;
    mode_d    = mode_q;
    bitCnt_d  = bitCnt_q;
    shift_d   = shift_q;
    op_d      = op_q;
    addrCnt_d = addrCnt_q;
    addr_d    = addr_q;
    txByte_d  = txByte_q;
    tx_d      = tx_q;
    misoOut_d = misoOut_q;
    misoOeN_d = misoOeN_q;
    stat_d    = stat_q;
    clrWel_d  = clrWel_q;
    bad_d     = bad_q;
    memWe     = 1'b0;
    if (!sel) begin
      // deselected: drop partial byte, tristate
      state_d   = S_IDLE;
      bitCnt_d  = 3'h0;
      tx_d      = 1'b0;
      misoOeN_d = 1'b1;
      if (selRise && clrWel_q) stat_d = stat_q & ~STATUS_WEL;
      clrWel_d  = 1'b0;
    end else if (selFall) begin
      // mode from clock level, one opcode per select
      mode_d   = sckS;
      armed_d  = ~sckS;
      state_d  = S_OPCODE;
      bitCnt_d = 3'h0;
      bad_d    = 1'b0;
    end else begin
      if (sckFall) begin
        armed_d = 1'b1;
        if (tx_q) begin
          // shift out on falling edge, driven only when reading
          misoOut_d = txByte_q[7];
          txByte_d  = {txByte_q[6:0], 1'b0};
          misoOeN_d = 1'b0;
        end
      end
      if (sckRise && armed_q && state_q != S_IDLE && state_q != S_IGNORE) begin
        bitCnt_d = bitCnt_q + 3'h1;         // capture on rising edge
        shift_d  = nb;
        if (bitCnt_q == 3'h7) begin
          case (state_q)
            S_OPCODE: begin
              op_d = nb;                     // first byte is opcode
              case (nb)
                OP_READ, OP_WRITE: begin
                  state_d   = S_ADDR;
                  addrCnt_d = 2'h0;
                end
                OP_RDSTAT: begin
                  state_d  = S_STAT;
                  tx_d     = 1'b1;
                  txByte_d = stat_q;
                end
                OP_WRSTAT: state_d = S_STAT;
                OP_WREN: begin
                  stat_d  = stat_q | STATUS_WEL;
                  state_d = S_IGNORE;
                end
                OP_WRDIS: begin
                  clrWel_d = 1'b1;
                  state_d  = S_IGNORE;
                end
                default: begin
                  state_d = S_IGNORE;        // unknown opcode
                  bad_d   = 1'b1;
                end
              endcase
            end
            S_ADDR: begin
              addr_d    = {addr_q[15:0], nb};
              addrCnt_d = addrCnt_q + 2'h1;
              if (addrCnt_q == 2'(ADDR_BYTES - 1)) begin
                state_d = S_DATA;
                if (op_q == OP_READ) begin
                  tx_d     = 1'b1;
                  txByte_d = mem[{addr_q[ADDR_USED-9:0], nb}];
                end
              end
            end
            S_DATA: begin
              // byte stored or fetched at once, no busy time
              if (op_q == OP_WRITE) begin
                memWe = stat_q[1];
              end else begin
                txByte_d = mem[ADDR_USED'(memAddr + 1'b1)];
              end
              addr_d = {addr_q[23:ADDR_USED], ADDR_USED'(memAddr + 1'b1)};
            end
            S_STAT: begin
              if (op_q == OP_WRSTAT && stat_q[1]) begin
                stat_d   = (nb & STATUS_WMASK) | (stat_q & ~STATUS_WMASK);
                clrWel_d = 1'b1;
              end else if (op_q == OP_RDSTAT) begin
                txByte_d = stat_q;
              end
            end
            default: state_d = S_IGNORE;
          endcase
          if (state_q == S_DATA && op_q == OP_WRITE) clrWel_d = stat_q[1];
        end
      end
    end
  end

  // register the engine
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= S_IDLE;
      selPrev_q <= 1'b0;
      sckPrev_q <= 1'b0;
      armed_q   <= 1'b0;
      mode_q    <= 1'b0;
      bitCnt_q  <= 3'h0;
      shift_q   <= 8'h00;
      op_q      <= 8'h00;
      addrCnt_q <= 2'h0;
      addr_q    <= 24'h000000;
      txByte_q  <= 8'h00;
      tx_q      <= 1'b0;
      misoOut_q <= 1'b0;
      misoOeN_q <= 1'b1;
      stat_q    <= STATUS_RESET;
      clrWel_q  <= 1'b0;
      bad_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      selPrev_q <= sel;
      sckPrev_q <= sckS;
      armed_q   <= armed_d;
      mode_q    <= mode_d;
      bitCnt_q  <= bitCnt_d;
      shift_q   <= shift_d;
      op_q      <= op_d;
      addrCnt_q <= addrCnt_d;
      addr_q    <= addr_d;
      txByte_q  <= txByte_d;
      tx_q      <= tx_d;
      misoOut_q <= misoOut_d;
      misoOeN_q <= misoOeN_d;
      stat_q    <= stat_d;
      clrWel_q  <= clrWel_d;
      bad_q     <= bad_d;
    end
  end

  // memory array write port
  always_ff @(posedge clk) begin
    if (memWe) mem[memAddr] <= shift_d;
  end

  assign link.misoOut = misoOut_q;
  assign link.misoOeN = misoOeN_q;  // released unless reading
  assign modeThree    = mode_q;
  assign opcodeBad    = bad_q;
  assign statusReg    = stat_q;
endmodule // spi_mem_device
`default_nettype wire

//--- core/spi_mem_master.sv
// master end of the serial memory link
`timescale 1ns/10ps
`default_nettype none
module spi_mem_master
  import spi_mem_pkg::*;
#(
  parameter int POWERUP_CNT = POWERUP_CYCLES,
  parameter int HALF_CNT    = SCK_HALF_CYCLES
) (
  // system
  input  wire logic       clk,
  input  wire logic       resetn,
  // serial link
  spi_mem_if.master       link,
  // user request
  input  wire logic       reqValid,
  input  wire logic [7:0] reqByte,
  input  wire logic       reqLast,
  input  wire logic       cpolHigh,
  output logic            reqReady,
  output logic            rspValid,
  output logic [7:0]      rspByte
);
  initial begin
    if (HALF_CNT < 3) $error("HALF_CNT too small");
    if (POWERUP_CNT < 1) $error("POWERUP_CNT too small");
  end

  typedef enum {M_WAIT, M_IDLE, M_LOW, M_HIGH, M_END} state_e;

  state_e      state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic [2:0]  bitN_q, bitN_d;
  logic [7:0]  tx_q, tx_d, rx_q, rx_d;
  logic        last_q, last_d, cpol_q, cpol_d;
  logic        selN_q, selN_d, sck_q, sck_d, mosi_q, mosi_d;
  logic        rdy_q, rdy_d, rv_q, rv_d;
  logic [1:0]  misoSync_q;

  // returned data synchroniser, master never drives this line
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) misoSync_q <= 2'h0;
    else misoSync_q <= {misoSync_q[0], link.misoLine};
  end

  // divider and byte sequencer, select held until last byte
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    bitN_d  = bitN_q;
    tx_d    = tx_q;
    rx_d    = rx_q;
    last_d  = last_q;
    cpol_d  = cpol_q;
    selN_d  = selN_q;
    sck_d   = sck_q;
    mosi_d  = mosi_q;
    rdy_d   = 1'b0;
    rv_d    = 1'b0;
    case (state_q)
      M_WAIT: begin                    // power-up access delay
        cnt_d = cnt_q + 32'h1;
        if (cnt_q >= 32'(POWERUP_CNT)) begin
          state_d = M_IDLE;
          cnt_d   = 32'h0;
        end
      end
      M_IDLE: begin
        // idle level settled and select high a while before a new frame
        if (selN_q) begin
          sck_d = cpolHigh;            // idle level per mode
          if (sck_q != cpolHigh) begin
            cnt_d = 32'h0;
          end else if (cnt_q != 32'(HALF_CNT)) begin
            cnt_d = cnt_q + 32'h1;     // select high gap
          end
        end
        rdy_d = ~reqValid;
        if (reqValid && !rdy_q &&
            (!selN_q || (cnt_q == 32'(HALF_CNT) && sck_q == cpolHigh))) begin
          rdy_d  = 1'b1;
          tx_d   = reqByte;
          last_d = reqLast;
          if (selN_q) cpol_d = cpolHigh;
          selN_d  = 1'b0;
          mosi_d  = reqByte[7];
          bitN_d  = 3'h0;
          cnt_d   = 32'h0;
          state_d = M_LOW;
          sck_d   = 1'b0;
          if (selN_q && cpolHigh) sck_d = 1'b1;
        end
      end
      M_LOW: begin                     // clock low phase, then rise
        cnt_d = cnt_q + 32'h1;
        if (cnt_q == 32'(HALF_CNT - 1)) begin
          cnt_d = 32'h0;
          if (sck_q) begin
            sck_d = 1'b0;              // mode 3 lead-in half, then first toggle
          end else begin
            sck_d   = 1'b1;
            state_d = M_HIGH;
          end
        end
      end
      M_HIGH: begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q == 32'(HALF_CNT - 1)) begin
          cnt_d  = 32'h0;
          rx_d   = {rx_q[6:0], misoSync_q[1]};
          bitN_d = bitN_q + 3'h1;
          tx_d   = {tx_q[6:0], 1'b0};
          mosi_d = tx_q[6];
          if (bitN_q == 3'h7) begin
            rv_d    = 1'b1;
            state_d = last_q ? M_END : M_IDLE;
            sck_d   = cpol_q;
          end else begin
            sck_d   = 1'b0;
            state_d = M_LOW;
          end
        end
      end
      M_END: begin                     // deselect between operations
        cnt_d = cnt_q + 32'h1;
        if (cnt_q == 32'(HALF_CNT - 1)) begin
          selN_d  = 1'b1;
          cnt_d   = 32'h0;
          state_d = M_IDLE;
        end
      end
      default: state_d = M_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= M_WAIT;
      cnt_q   <= 32'h0;
      bitN_q  <= 3'h0;
      tx_q    <= 8'h00;
      rx_q    <= 8'h00;
      last_q  <= 1'b0;
      cpol_q  <= 1'b0;
      selN_q  <= 1'b1;
      sck_q   <= 1'b0;
      mosi_q  <= 1'b0;
      rdy_q   <= 1'b0;
      rv_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      bitN_q  <= bitN_d;
      tx_q    <= tx_d;
      rx_q    <= rx_d;
      last_q  <= last_d;
      cpol_q  <= cpol_d;
      selN_q  <= selN_d;
      sck_q   <= sck_d;
      mosi_q  <= mosi_d;
      rdy_q   <= rdy_d & reqValid;
      rv_q    <= rv_d;
    end
  end

  assign link.selN = selN_q;
  assign link.sck  = sck_q;
  assign link.mosi = mosi_q;
  assign reqReady  = rdy_q;
  assign rspValid  = rv_q;
  assign rspByte   = rx_q;
endmodule // spi_mem_master
`default_nettype wire

//--- bench/spi_mem_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module spi_mem_assertions
  import spi_mem_pkg::*;
#(
  parameter int POWERUP_CNT = POWERUP_CYCLES
) (
  // system
  input wire logic clk,
  input wire logic resetn,
  // serial link
  input wire logic selN,
  input wire logic sck,
  input wire logic mosi,
  input wire logic misoOut,
  input wire logic misoOeN
);
  logic        sck_q, sck_d;
  logic [5:0]  rise_q, rise_d;
  logic [15:0] up_q, up_d;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // sck rises inside a frame, cycles since reset
  always_comb begin
    sck_d  = sck;
    rise_d = rise_q;
    if (selN) begin
      rise_d = 6'h00;
    end else if (sck && !sck_q && rise_q != 6'h3f) begin
      rise_d = rise_q + 6'h01;
    end
    up_d = (up_q == 16'hffff) ? up_q : up_q + 16'h0001;
  end

  // helper registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_q  <= 1'b0;
      rise_q <= 6'h00;
      up_q   <= 16'h0000;
    end else begin
      sck_q  <= sck_d;
      rise_q <= rise_d;
      up_q   <= up_d;
    end
  end

  chk_oe_deselect: assert property (selN [*6] |-> misoOeN)
    else $error("output driven while deselected");
  chk_data_after_cmd: assert property ($fell(misoOeN) |-> rise_q >= 6'h08)
    else $error("output driven inside opcode");
  chk_miso_on_fall: assert property (
    !misoOeN && $past(!misoOeN) && !$stable(misoOut) |-> !sck)
    else $error("output changed while clock high");
  chk_mosi_setup: assert property (
    $rose(sck) && !selN |-> $stable(mosi) && mosi == $past(mosi, 2))
    else $error("data moved near rising clock");
  chk_sck_idle_hold: assert property ($fell(selN) |-> $stable(sck) [*2])
    else $error("clock moved at select fall");
  chk_sck_half_min: assert property (!$stable(sck) |=> $stable(sck) [*2])
    else $error("clock half period too short");
  chk_sel_gap: assert property ($rose(selN) |-> selN [*3])
    else $error("select high gap too short");
  chk_powerup_wait: assert property (!selN |-> {16'h0000, up_q} >= POWERUP_CNT - 1)
    else $error("select before power-up delay");
endmodule // spi_mem_assertions
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import spi_mem_pkg::*;
;
  localparam int PU = 10;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       reqValid = 1'b0;
  logic [7:0] reqByte = 8'h00;
  logic       reqLast = 1'b0;
  logic       cpolHigh = 1'b0;
  logic       reqReady, rspValid, modeThree, opcodeBad, modeB, badB;
  logic [7:0] rspByte, statusReg, statusB, opSeen, mosiSh, misoSh;
  logic       oeLow = 1'b0;
  logic       oeLowB = 1'b0;
  int         fails = 0;
  int         cmpCount = 0;
  int         bitCnt = 0;

  spi_mem_if link();
  spi_mem_if linkB();

  // clock generator
  always #25 clk = ~clk;

  spi_mem_master #(.POWERUP_CNT(PU), .HALF_CNT(SCK_HALF_CYCLES)) spi_mem_master_inst (
    .clk(clk), .resetn(resetn), .link(link), .reqValid(reqValid), .reqByte(reqByte),
    .reqLast(reqLast), .cpolHigh(cpolHigh), .reqReady(reqReady), .rspValid(rspValid),
    .rspByte(rspByte));
  spi_mem_device spi_mem_device_inst (
    .clk(clk), .resetn(resetn), .link(link), .modeThree(modeThree),
    .opcodeBad(opcodeBad), .statusReg(statusReg));
  spi_mem_device spi_mem_device_inst_b (
    .clk(clk), .resetn(resetn), .link(linkB), .modeThree(modeB),
    .opcodeBad(badB), .statusReg(statusB));
  spi_mem_assertions #(.POWERUP_CNT(PU)) spi_mem_assertions_inst (
    .clk(clk), .resetn(resetn), .selN(link.selN), .sck(link.sck), .mosi(link.mosi),
    .misoOut(link.misoOut), .misoOeN(link.misoOeN));

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // idle clock level at select fall, bits seen on the wire
  always @(negedge link.selN) begin
    bitCnt = 0;
    cmp8({7'h00, link.sck}, {7'h00, cpolHigh});
  end
  always @(posedge link.sck) begin
    if (link.selN === 1'b0) begin
      mosiSh = {mosiSh[6:0], link.mosi};
      bitCnt++;
      if (bitCnt == 8) opSeen = mosiSh;
      if (link.misoOeN === 1'b0) misoSh = {misoSh[6:0], link.misoOut};
    end
  end
  // sticky record of any output drive
  always @(posedge clk) begin
    if (link.misoOeN === 1'b0) oeLow <= 1'b1;
    if (linkB.misoOeN === 1'b0) oeLowB <= 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // one select frame of n bytes taken from the top of b
  task automatic frame(input logic [39:0] b, input int n, input logic m, output logic [7:0] r);
    int k;
    cpolHigh = m;
    for (int i = 0; i < n; i++) begin
      reqByte = b[39-8*i -: 8];
      reqLast = (i == n - 1);
      reqValid = 1'b1;
      k = 0;
      do begin
        @(posedge clk);
        #2;
        k++;
      end while (reqReady !== 1'b1 && k < 9000);
      reqValid = 1'b0;
      // select has just fallen, the previous frame is released by now
      if (i == 0) oeLow = 1'b0;
      do begin
        @(posedge clk);
        #2;
        k++;
      end while (rspValid !== 1'b1 && k < 9000);
      r = rspByte;
      if (k >= 9000) begin
        fails++;
        report_and_stop();
      end
    end
  endtask

  task automatic rdstat(input logic m, input logic [7:0] e);
    logic [7:0] r;
    frame({OP_RDSTAT, 32'h0}, 2, m, r);
    cmp8(r, e);
    cmp8(opSeen, OP_RDSTAT);
  endtask

  task automatic t_reset();
    cmp8(statusReg, STATUS_RESET);
    cmp8({7'h00, link.misoOeN}, 8'h01);
  endtask

  task automatic t_modes();
    logic [7:0] r;
    rdstat(1'b0, STATUS_RESET);
    cmp8({7'h00, modeThree}, 8'h00);
    frame({OP_WREN, 32'h0}, 1, 1'b1, r);
    cmp8({7'h00, modeThree}, 8'h01);
    rdstat(1'b1, STATUS_RESET | STATUS_WEL);
    frame({OP_WRDIS, 32'h0}, 1, 1'b0, r);
    rdstat(1'b0, STATUS_RESET);
  endtask

  task automatic t_memory();
    logic [7:0] r;
    frame({OP_WREN, 32'h0}, 1, 1'b0, r);
    frame({OP_WRITE, 24'hf80012, 8'ha5}, 5, 1'b0, r);
    frame({OP_WREN, 32'h0}, 1, 1'b1, r);
    frame({OP_WRITE, 24'h040012, 8'h3c}, 5, 1'b1, r);
    frame({OP_READ, 24'h000012, 8'h00}, 5, 1'b0, r);
    cmp8(r, 8'ha5);
    cmp8(misoSh, 8'ha5);
    frame({OP_READ, 24'h040012, 8'h00}, 5, 1'b1, r);
    cmp8(r, 8'h3c);
    rdstat(1'b0, STATUS_RESET);
    frame({OP_WREN, 32'h0}, 1, 1'b0, r);
    frame({OP_WRSTAT, 8'h80, 24'h0}, 2, 1'b0, r);
    rdstat(1'b0, STATUS_RESET | (8'h80 & STATUS_WMASK));
  endtask

  task automatic t_bad_op();
    logic [7:0] r;
    frame({8'h9f, OP_RDSTAT, 24'h0}, 3, 1'b0, r);
    cmp8({7'h00, opcodeBad}, 8'h01);
    cmp8({7'h00, oeLow}, 8'h00);
    rdstat(1'b0, STATUS_RESET | 8'h80);
    cmp8({7'h00, opcodeBad}, 8'h00);
  endtask

  // bench-driven mode 0 bits on the second link
  task automatic drv(input logic [7:0] v, input int nb, output logic [7:0] g);
    for (int i = 0; i < nb; i++) begin
      linkB.mosi = v[7-i];
      tick(SCK_HALF_CYCLES);
      linkB.sck = 1'b1;
      g = {g[6:0], linkB.misoOut};
      tick(SCK_HALF_CYCLES);
      linkB.sck = 1'b0;
    end
  endtask

  task automatic selB(input logic s);
    linkB.selN = s;
    tick(8);
  endtask

  task automatic t_partial();
    logic [7:0] g;
    selB(1'b0);
    drv(8'hff, 3, g);
    selB(1'b1);
    drv(OP_WREN, 8, g);
    cmp8(statusB, STATUS_RESET);
    selB(1'b0);
    drv(OP_RDSTAT, 8, g);
    cmp8({7'h00, modeB}, 8'h00);
    drv(8'h00, 8, g);
    cmp8(g, STATUS_RESET);
    cmp8({7'h00, badB}, 8'h00);
    selB(1'b1);
    oeLowB = 1'b0;
    selB(1'b0);
    drv(8'h9f, 8, g);
    drv(OP_RDSTAT, 8, g);
    drv(8'h00, 8, g);
    cmp8({7'h00, badB}, 8'h01);
    cmp8({7'h00, oeLowB}, 8'h00);
    selB(1'b1);
  endtask

  // main sequence
  initial begin
    linkB.selN = 1'b1;
    linkB.sck = 1'b0;
    linkB.mosi = 1'b0;
    tick(20);
    resetn = 1'b1;
    tick(2);
    t_reset();
    t_modes();
    t_memory();
    t_bad_op();
    t_partial();
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
